// *** hw/cks_clk_div.sv ***
// Converter clock enable divider
`timescale 1ns/1ps
module cks_clk_div (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  // Tick interface
  cks_tick_if.div   tif
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       slow_prev;
    logic       slow_half;
    logic       tick;
  } cks_div_state_type;

  cks_div_state_type s_q;
  cks_div_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.slow_prev = tif.slow_s;
    if (!tif.en) begin
      s_d = '0;
    end else if (tif.sel == cks_pkg::CS_SLOW) begin
      // Slow oscillator halved: every second rising edge
      if (tif.slow_s && !s_q.slow_prev) begin
        s_d.slow_half = !s_q.slow_half;
        s_d.tick = s_q.slow_half;
      end
    end else if (s_q.cnt >= cks_pkg::div_last(tif.sel)) begin
      s_d.cnt = 5'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.tick = s_q.tick;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  chk_div_two_rate: assert property (
    (tif.tick && tif.en && tif.sel == 3'h0) ##1 (tif.en && tif.sel == 3'h0) |-> ##1 tif.tick)
    else $error("divide by two tick missing");
  chk_div_no_early: assert property (
    (tif.tick && tif.en && tif.sel == 3'h6) ##1 (tif.en && tif.sel == 3'h6) [*8] |-> !tif.tick)
    else $error("divide by thirty-two tick too early");

endmodule

// *** hw/cks_lfsr.sv ***
// Pseudo-random source for phase timing dither
`timescale 1ns/1ps
module cks_lfsr (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  // Tick interface
  cks_tick_if.rng   tif
);

  typedef struct packed {
    logic [15:0] lfsr;
  } cks_rng_state_type;

  cks_rng_state_type s_q;
  cks_rng_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (!tif.en) begin
      s_d.lfsr = cks_pkg::LFSR_SEED;
    end else if (tif.tick) begin
      s_d.lfsr = s_q.lfsr[0] ? ((s_q.lfsr >> 1) ^ cks_pkg::LFSR_TAPS) : (s_q.lfsr >> 1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_q.lfsr <= cks_pkg::LFSR_SEED;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.rnd = s_q.lfsr;

  chk_lfsr_alive: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_q.lfsr != 16'h0000)
    else $error("random source locked at zero");

endmodule

// *** hw/cks_pkg.sv ***
// Shared constants, register map and types of the capacitive key sequencer
package cks_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CFG  = 8'h00;
  localparam logic [7:0] ADDR_CTL  = 8'h04;
  localparam logic [7:0] ADDR_THR  = 8'h08;
  localparam logic [7:0] ADDR_CHG  = 8'h0c;
  localparam logic [7:0] ADDR_DIS  = 8'h10;
  localparam logic [7:0] ADDR_BASE = 8'h14;
  localparam logic [7:0] ADDR_ACC  = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  localparam logic [7:0] ADDR_CLR  = 8'h20;
  localparam logic [7:0] ADDR_IEN  = 8'h24;

  // touch_sense_config_a fields
  localparam int CFG_EN_POS     = 7;
  localparam int CFG_CS_LSB     = 4;
  localparam int CFG_SHIELD_POS = 3;
  localparam int CFG_IEN_POS    = 2;
  localparam int CFG_LPM_POS    = 1;
  localparam int CFG_AUTO_POS   = 0;

  // Control register fields
  localparam int CTL_START_POS = 0;
  localparam int CTL_REP_LSB   = 1;
  localparam int CTL_REL_POS   = 3;

  // Status, clear and enable layout
  localparam int STAT_DONE_POS = 0;
  localparam int STAT_WAKE_POS = 1;

  // Reset values and random source taps
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [15:0] THR_RST  = 16'h0040;
  localparam logic [1:0]  IEN_RST  = 2'h0;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

  // Counting limits, baseline averaging depth (1/32 step) and slow clock select code
  localparam logic [15:0] COUNT_MAX  = 16'hffff;
  localparam int          BASE_SHIFT = 5;
  localparam logic [2:0]  CS_SLOW    = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_GAP_UP, ST_CHARGE, ST_GAP_DN, ST_DISCH, ST_EVAL
  } cks_state_type;

  // Last count of the system clock divider: ratio 2,4,6,8,10,16,32
  function automatic logic [4:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0:    div_last = 5'h01;
      3'h1:    div_last = 5'h03;
      3'h2:    div_last = 5'h05;
      3'h3:    div_last = 5'h07;
      3'h4:    div_last = 5'h09;
      3'h5:    div_last = 5'h0f;
      default: div_last = 5'h1f;
    endcase
  endfunction

  // Repeat select: 1, 4, 8 or 16 conversions per sequence
  function automatic logic [3:0] rep_last(input logic [1:0] sel);
    case (sel)
      2'h0:    rep_last = 4'h0;
      2'h1:    rep_last = 4'h3;
      2'h2:    rep_last = 4'h7;
      default: rep_last = 4'hf;
    endcase
  endfunction

  function automatic logic [2:0] rep_shift(input logic [1:0] sel);
    case (sel)
      2'h0:    rep_shift = 3'h0;
      2'h1:    rep_shift = 3'h2;
      2'h2:    rep_shift = 3'h3;
      default: rep_shift = 3'h4;
    endcase
  endfunction

endpackage

// *** hw/cks_seq.sv ***
// Dual-slope capacitive key sequencer with APB registers
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Function
// - Every conversion runs a charge phase then a discharge phase, each counted.
// - Total charge-phase converter periods kept in a 16-bit result.
// - Total discharge-phase converter periods kept in a separate 16-bit result.
// - A pseudo-random sequence varies phase timing to reject high-frequency noise.
// - Up to 16 conversions accumulate into a 20-bit result.
// - A slow moving average of the duty count forms a readable 16-bit baseline.
// - Unit enable low stops the converter and clears its state.
// - Clock select picks system clock /2../32 or slow oscillator /2.
// - Shield enable turns on the buffer replicating the key signal.
// - Each converter interrupt also sets the interrupt flag.
// - Auto mode compares duty with baseline plus threshold; higher raises interrupt, wakeup.
// - Normal mode: start bit launches one sequence, interrupt when duty ready.
module cks_seq (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Analog front end
  input  wire logic        i_cmp,
  input  wire logic        i_slow_osc,
  output logic             o_afe_en,
  output logic             o_charge,
  output logic             o_discharge,
  output logic             o_shield_en,
  output logic             o_low_power,
  // Events
  output logic             o_irq,
  output logic             o_wakeup
);

  typedef struct packed {
    logic [7:0]            cfg;
    logic [1:0]            rep_sel;
    logic                  rel;
    logic [15:0]           thr;
    cks_pkg::cks_state_type st;
    logic [1:0]            gap;
    logic [3:0]            rep;
    logic [15:0]           chg_run;
    logic [15:0]           dis_run;
    logic [19:0]           acc_run;
    logic [15:0]           chg_res;
    logic [15:0]           dis_res;
    logic [19:0]           acc_res;
    logic [15:0]           base;
    logic                  base_ok;
    logic [1:0]            stat;
    logic [1:0]            ien;
    logic                  wake;
    logic                  irq;
    logic                  chg_drv;
    logic                  dis_drv;
    logic                  shield;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  cmp_m;
    logic                  cmp_s;
    logic                  slow_m;
    logic                  slow_s;
  } cks_seq_state_type;

  localparam cks_seq_state_type SEQ_RST = '{
    cfg: cks_pkg::CFG_RST, thr: cks_pkg::THR_RST, ien: cks_pkg::IEN_RST,
    st: cks_pkg::ST_IDLE, default: '0};

  cks_seq_state_type s_q;
  cks_seq_state_type s_d;

  cks_tick_if tif ();

  cks_clk_div u_div (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .tif       (tif)
  );

  cks_lfsr u_rng (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .tif       (tif)
  );

  assign tif.en     = s_q.cfg[cks_pkg::CFG_EN_POS];
  assign tif.sel    = s_q.cfg[cks_pkg::CFG_CS_LSB +: 3];
  assign tif.slow_s = s_q.slow_s;

  logic        cfg_en;
  logic        cfg_auto;
  logic [15:0] duty_w;
  logic [16:0] limit_w;
  logic        detect_w;

  assign cfg_en   = s_q.cfg[cks_pkg::CFG_EN_POS];
  assign cfg_auto = s_q.cfg[cks_pkg::CFG_AUTO_POS];
  // Average of the accumulated charge counts
  assign duty_w   = 16'(s_q.acc_run >> cks_pkg::rep_shift(s_q.rep_sel));
  // Relative threshold is the baseline scaled down by a power of two
  assign limit_w  = {1'b0, s_q.base} +
                    (s_q.rel ? {1'b0, s_q.base >> s_q.thr[3:0]} : {1'b0, s_q.thr});
  assign detect_w = cfg_auto && s_q.base_ok && ({1'b0, duty_w} > limit_w);

  always_comb begin
    logic        wr;
    logic        start;
    logic [1:0]  set_v;
    logic [1:0]  clr_v;
    logic [16:0] diff;
    logic [16:0] step;
    wr    = i_psel && i_penable && s_q.pready && i_pwrite && !s_q.pslverr;
    start = 1'b0;
    set_v = 2'h0;
    clr_v = 2'h0;
    diff  = {1'b0, duty_w} - {1'b0, s_q.base};
    step  = 17'($signed(diff) >>> cks_pkg::BASE_SHIFT);

    s_d = s_q;
    s_d.cmp_m   = i_cmp;
    s_d.cmp_s   = s_q.cmp_m;
    s_d.slow_m  = i_slow_osc;
    s_d.slow_s  = s_q.slow_m;
    s_d.wake    = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;

    // Setup phase: decode and register the answer, access phase follows without wait
    if (i_psel && !i_penable) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (i_paddr == cks_pkg::ADDR_CFG) begin
        s_d.prdata = {24'h00_0000, s_q.cfg};
      end else if (i_paddr == cks_pkg::ADDR_CTL) begin
        s_d.prdata = {28'h000_0000, s_q.rel, s_q.rep_sel, s_q.st != cks_pkg::ST_IDLE};
      end else if (i_paddr == cks_pkg::ADDR_THR) begin
        s_d.prdata = {16'h0000, s_q.thr};
      end else if (i_paddr == cks_pkg::ADDR_CHG) begin
        s_d.prdata = {16'h0000, s_q.chg_res};
      end else if (i_paddr == cks_pkg::ADDR_DIS) begin
        s_d.prdata = {16'h0000, s_q.dis_res};
      end else if (i_paddr == cks_pkg::ADDR_BASE) begin
        s_d.prdata = {16'h0000, s_q.base};
      end else if (i_paddr == cks_pkg::ADDR_ACC) begin
        s_d.prdata = {12'h000, s_q.acc_res};
      end else if (i_paddr == cks_pkg::ADDR_STAT) begin
        s_d.prdata = {30'h0000_0000, s_q.stat};
      end else if (i_paddr == cks_pkg::ADDR_CLR) begin
        s_d.prdata = 32'h0000_0000;
      end else if (i_paddr == cks_pkg::ADDR_IEN) begin
        s_d.prdata = {30'h0000_0000, s_q.ien};
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    if (wr) begin
      if (i_paddr == cks_pkg::ADDR_CFG) begin
        s_d.cfg = i_pwdata[7:0];
      end else if (i_paddr == cks_pkg::ADDR_CTL) begin
        s_d.rep_sel = i_pwdata[cks_pkg::CTL_REP_LSB +: 2];
        s_d.rel     = i_pwdata[cks_pkg::CTL_REL_POS];
        start       = i_pwdata[cks_pkg::CTL_START_POS];
      end else if (i_paddr == cks_pkg::ADDR_THR) begin
        s_d.thr = i_pwdata[15:0];
      end else if (i_paddr == cks_pkg::ADDR_CLR) begin
        clr_v = i_pwdata[1:0];
      end else if (i_paddr == cks_pkg::ADDR_IEN) begin
        s_d.ien = i_pwdata[1:0];
      end
    end

    case (s_q.st)
      cks_pkg::ST_IDLE: begin
        // Auto mode relaunches by itself; normal mode waits for a start write
        if (cfg_en && (cfg_auto || start)) begin
          s_d.chg_run = 16'h0000;
          s_d.dis_run = 16'h0000;
          s_d.acc_run = 20'h0_0000;
          s_d.rep     = 4'h0;
          s_d.gap     = tif.rnd[1:0];
          s_d.st      = cks_pkg::ST_GAP_UP;
        end
      end
      cks_pkg::ST_GAP_UP: begin
        if (tif.tick) begin
          if (s_q.gap == 2'h0) begin
            s_d.st = cks_pkg::ST_CHARGE;
          end else begin
            s_d.gap = s_q.gap - 2'h1;
          end
        end
      end
      cks_pkg::ST_CHARGE: begin
        if (tif.tick) begin
          // Counter saturation also ends a stuck phase
          if (s_q.cmp_s || s_q.chg_run == cks_pkg::COUNT_MAX) begin
            s_d.gap = tif.rnd[1:0];
            s_d.st  = cks_pkg::ST_GAP_DN;
          end else begin
            s_d.chg_run = s_q.chg_run + 16'h0001;
            s_d.acc_run = s_q.acc_run + 20'h0_0001;
          end
        end
      end
      cks_pkg::ST_GAP_DN: begin
        if (tif.tick) begin
          if (s_q.gap == 2'h0) begin
            s_d.st = cks_pkg::ST_DISCH;
          end else begin
            s_d.gap = s_q.gap - 2'h1;
          end
        end
      end
      cks_pkg::ST_DISCH: begin
        if (tif.tick) begin
          if (!s_q.cmp_s || s_q.dis_run == cks_pkg::COUNT_MAX) begin
            if (s_q.rep >= cks_pkg::rep_last(s_q.rep_sel)) begin
              s_d.st = cks_pkg::ST_EVAL;
            end else begin
              s_d.rep = s_q.rep + 4'h1;
              s_d.gap = tif.rnd[1:0];
              s_d.st  = cks_pkg::ST_GAP_UP;
            end
          end else begin
            s_d.dis_run = s_q.dis_run + 16'h0001;
          end
        end
      end
      cks_pkg::ST_EVAL: begin
        s_d.chg_res = s_q.chg_run;
        s_d.dis_res = s_q.dis_run;
        s_d.acc_res = s_q.acc_run;
        // First result seeds the baseline, later ones move it by 1/32 of the error
        if (!s_q.base_ok) begin
          s_d.base    = duty_w;
          s_d.base_ok = 1'b1;
        end else begin
          s_d.base = s_q.base + step[15:0];
        end
        if (!cfg_auto) begin
          set_v[cks_pkg::STAT_DONE_POS] = 1'b1;
        end else if (detect_w) begin
          set_v  = 2'h3;
          s_d.wake = 1'b1;
        end
        s_d.st = cks_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = cks_pkg::ST_IDLE;
      end
    endcase

    // A set in the same cycle as its clear wins
    s_d.stat = (s_q.stat & ~clr_v) | set_v;

    if (!s_d.cfg[cks_pkg::CFG_EN_POS]) begin
      s_d.st      = cks_pkg::ST_IDLE;
      s_d.gap     = 2'h0;
      s_d.rep     = 4'h0;
      s_d.chg_run = 16'h0000;
      s_d.dis_run = 16'h0000;
      s_d.acc_run = 20'h0_0000;
      s_d.chg_res = 16'h0000;
      s_d.dis_res = 16'h0000;
      s_d.acc_res = 20'h0_0000;
      s_d.base    = 16'h0000;
      s_d.base_ok = 1'b0;
      s_d.stat    = 2'h0;
      s_d.wake    = 1'b0;
    end

    s_d.irq = s_d.cfg[cks_pkg::CFG_IEN_POS] && |(s_d.stat & s_d.ien);
    s_d.chg_drv = s_d.st == cks_pkg::ST_CHARGE;
    s_d.dis_drv = s_d.st == cks_pkg::ST_DISCH;
    s_d.shield  = s_d.cfg[cks_pkg::CFG_EN_POS] && s_d.cfg[cks_pkg::CFG_SHIELD_POS];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s_q <= SEQ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata    = s_q.prdata;
  assign o_pready    = s_q.pready;
  assign o_pslverr   = s_q.pslverr;
  assign o_afe_en    = s_q.cfg[cks_pkg::CFG_EN_POS];
  assign o_charge    = s_q.chg_drv;
  assign o_discharge = s_q.dis_drv;
  assign o_shield_en = s_q.shield;
  assign o_low_power = s_q.cfg[cks_pkg::CFG_LPM_POS];
  assign o_irq       = s_q.irq;
  assign o_wakeup    = s_q.wake;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  chk_phase_excl: assert property (!(o_charge && o_discharge))
    else $error("charge and discharge driven together");
  chk_disch_after_chg: assert property (
    (s_q.st == cks_pkg::ST_GAP_DN && $past(s_q.st) != cks_pkg::ST_GAP_DN && cfg_en)
    |-> $past(s_q.st) == cks_pkg::ST_CHARGE)
    else $error("discharge gap entered without a charge phase");
  chk_chg_count: assert property (
    (s_q.st == cks_pkg::ST_CHARGE && tif.tick && !s_q.cmp_s && s_q.chg_run != 16'hffff
     && s_d.cfg[cks_pkg::CFG_EN_POS]) |=> s_q.chg_run == $past(s_q.chg_run) + 16'h0001)
    else $error("charge count did not advance");
  chk_dis_count: assert property (
    (s_q.st == cks_pkg::ST_DISCH && tif.tick && s_q.cmp_s && s_q.dis_run != 16'hffff
     && s_d.cfg[cks_pkg::CFG_EN_POS]) |=> s_q.dis_run == $past(s_q.dis_run) + 16'h0001)
    else $error("discharge count did not advance");
  chk_gap_random: assert property (
    (s_q.st == cks_pkg::ST_GAP_UP && $past(s_q.st) != cks_pkg::ST_GAP_UP)
    |-> s_q.gap == $past(tif.rnd[1:0]))
    else $error("phase gap not taken from random source");
  chk_acc_latch: assert property (
    (s_q.st == cks_pkg::ST_EVAL && s_d.cfg[cks_pkg::CFG_EN_POS])
    |=> s_q.acc_res == $past(s_q.acc_run) && s_q.chg_res == $past(s_q.chg_run))
    else $error("accumulated result not latched");
  chk_base_still: assert property (
    (s_q.st != cks_pkg::ST_EVAL && s_d.cfg[cks_pkg::CFG_EN_POS]) |=> $stable(s_q.base))
    else $error("baseline moved outside evaluation");
  chk_disable_clear: assert property (
    !s_d.cfg[cks_pkg::CFG_EN_POS] |=> s_q.st == cks_pkg::ST_IDLE && s_q.stat == 2'h0
    && s_q.base == 16'h0000 && !o_charge && !o_discharge)
    else $error("disabled unit kept state");
  chk_shield_buf: assert property (
    o_shield_en |-> o_afe_en && $past(s_d.cfg[cks_pkg::CFG_SHIELD_POS]))
    else $error("shield buffer on without enable");
  chk_flag_done: assert property (
    (s_q.st == cks_pkg::ST_EVAL && !cfg_auto && s_d.cfg[cks_pkg::CFG_EN_POS])
    |=> s_q.stat[cks_pkg::STAT_DONE_POS] && s_q.st == cks_pkg::ST_IDLE)
    else $error("interrupt flag not set on completion");
  chk_auto_wake: assert property (
    (s_q.st == cks_pkg::ST_EVAL && detect_w && s_d.cfg[cks_pkg::CFG_EN_POS])
    |=> o_wakeup && s_q.stat == 2'h3 ##1 !o_wakeup)
    else $error("detection did not raise wakeup and flag");
  chk_start_launch: assert property (
    (s_q.st == cks_pkg::ST_IDLE && cfg_en && !cfg_auto && !s_q.pready)
    |=> s_q.st == cks_pkg::ST_IDLE)
    else $error("sequence launched without a start write");
  chk_irq_gate: assert property (
    o_irq |-> $past(s_d.cfg[cks_pkg::CFG_IEN_POS]) && |(s_q.stat & s_q.ien))
    else $error("interrupt raised without enabled flag");

  cov_normal_done: cover property (
    s_q.st == cks_pkg::ST_EVAL && !cfg_auto ##1 o_irq);
  cov_auto_wake: cover property (o_wakeup);
  cov_repeat_16: cover property (
    s_q.st == cks_pkg::ST_EVAL && s_q.rep_sel == 2'h3);

endmodule

// *** hw/cks_tick_if.sv ***
// Converter tick and random source shared between the sequencer and its helpers
`timescale 1ns/1ps
interface cks_tick_if;
  logic        en;
  logic [2:0]  sel;
  logic        slow_s;
  logic        tick;
  logic [15:0] rnd;

  modport div  (input en, input sel, input slow_s, output tick);
  modport rng  (input en, input tick, output rnd);
  modport core (output en, output sel, output slow_s, input tick, input rnd);
endinterface

// *** sim/cks_afe_model.sv ***
// Behavioural analog front end: comparator follows the phase drive after set delays
`timescale 1ns/1ps
module cks_afe_model (
  // Clock
  input  wire logic       i_clk_sys,
  // Phase drive and ramp times in system cycles
  input  wire logic       i_charge,
  input  wire logic       i_discharge,
  input  wire logic [7:0] i_up,
  input  wire logic [7:0] i_dn,
  // Comparator and slow oscillator
  output logic            o_cmp,
  output logic            o_slow_osc
);
  logic [7:0] cnt_q;
  logic [3:0] osc_q;
  logic [1:0] ph_q;

  initial begin
    o_cmp = 1'b0;
    cnt_q = 8'h00;
    osc_q = 4'h0;
    ph_q  = 2'h0;
  end

  // Ramp time restarts at each phase change, gaps included; a stale count never trips a phase
  always @(posedge i_clk_sys) begin
    osc_q <= osc_q + 4'h1;
    ph_q  <= {i_charge, i_discharge};
    if ({i_charge, i_discharge} != ph_q) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      if (i_charge && cnt_q >= i_up) o_cmp <= 1'b1;
      if (i_discharge && cnt_q >= i_dn) o_cmp <= 1'b0;
    end
  end

  assign o_slow_osc = osc_q[3];
endmodule

// *** sim/cks_seq_bench.sv ***
// Self-checking bench for the capacitive key sequencer
`timescale 1ns/1ps
module cks_seq_bench;
  logic        i_clk_sys, i_nrst, i_psel, i_penable, i_pwrite, er, wake_seen;
  logic [7:0]  i_paddr, up, dn;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, i_cmp, i_slow_osc, o_afe_en, o_charge, o_discharge;
  logic        o_shield_en, o_low_power, o_irq, o_wakeup;
  int          num_errors, checks_done;

  cks_seq dut (.i_clk_sys, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_cmp, .i_slow_osc, .o_afe_en, .o_charge,
    .o_discharge, .o_shield_en, .o_low_power, .o_irq, .o_wakeup);
  cks_afe_model afe (.i_clk_sys, .i_charge(o_charge), .i_discharge(o_discharge),
    .i_up(up), .i_dn(dn), .o_cmp(i_cmp), .o_slow_osc(i_slow_osc));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) if (o_wakeup === 1'b1) wake_seen <= 1'b1;

  task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: got %h, want %h..%h", $time, got, lo, hi);
    end
  endtask

  // Idle cycle after each transfer keeps select from being driven twice in one step
  // A slave that never answers is caught by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (o_irq !== 1'b1 && n < lim) begin
      @(posedge i_clk_sys);
      n++;
    end
    check(32'(o_irq), 1, 1);
  endtask

  task automatic conv(input logic [7:0] cfg, input logic [1:0] rep);
    apb(1'b1, cks_pkg::ADDR_CFG, {24'h0, cfg});
    apb(1'b1, cks_pkg::ADDR_IEN, 32'h3);
    apb(1'b1, cks_pkg::ADDR_CTL, {29'h0, rep, 1'b1});
    wait_irq(3000);
    apb(1'b1, cks_pkg::ADDR_CLR, 32'h3);
    repeat (2) @(posedge i_clk_sys);
    check(32'(o_irq), 0, 0);
  endtask

  task automatic t_reset();
    apb(1'b0, cks_pkg::ADDR_CFG, 32'h0);
    check(rd, 0, 0);
    apb(1'b0, cks_pkg::ADDR_THR, 32'h0);
    check(rd, 32'h40, 32'h40);
    apb(1'b0, 8'h30, 32'h0);
    check(32'(er), 1, 1);
  endtask

  task automatic t_normal();
    conv(8'h84, 2'h0);
    apb(1'b0, cks_pkg::ADDR_CHG, 32'h0);
    check(rd, 18, 24);
    apb(1'b0, cks_pkg::ADDR_DIS, 32'h0);
    check(rd, 8, 14);
  endtask

  task automatic t_clocks();
    for (int cs = 0; cs < 8; cs++) begin
      conv({1'b1, 3'(cs), 4'h4}, 2'h0);
      apb(1'b0, cks_pkg::ADDR_CHG, 32'h0);
      check(rd, 1, 24);
    end
  endtask

  // Disabling first clears the baseline, so this sequence seeds it afresh
  task automatic t_repeat();
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h0);
    conv(8'h84, 2'h1);
    apb(1'b0, cks_pkg::ADDR_ACC, 32'h0);
    check(rd, 72, 96);
    apb(1'b0, cks_pkg::ADDR_BASE, 32'h0);
    check(rd, 18, 24);
  endtask

  // Flag set with interrupt enable off, then enable shows it at once
  task automatic t_mask();
    int n;
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h80);
    apb(1'b1, cks_pkg::ADDR_CTL, 32'h1);
    n = 0;
    do begin
      apb(1'b0, cks_pkg::ADDR_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 200);
    check(32'(rd[0]), 1, 1);
    check(32'(o_irq), 0, 0);
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h84);
    wait_irq(3);
    apb(1'b1, cks_pkg::ADDR_CLR, 32'h3);
  endtask

  // Relative limit is base 22 plus 22/16, so 23; a duty of 24 trips only the relative limit
  task automatic t_auto();
    int n;
    apb(1'b1, cks_pkg::ADDR_THR, 32'h4);
    apb(1'b1, cks_pkg::ADDR_CTL, 32'h8);
    wake_seen <= 1'b0;
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h85);
    repeat (2000) @(posedge i_clk_sys);
    check(32'(wake_seen), 0, 0);
    up <= 8'd44;
    n = 0;
    while (wake_seen !== 1'b1 && n < 3000) begin
      @(posedge i_clk_sys);
      n++;
    end
    check(32'(wake_seen), 1, 1);
    apb(1'b0, cks_pkg::ADDR_STAT, 32'h0);
    check(32'(rd[1]), 1, 1);
    up <= 8'd40;
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h84);
    apb(1'b1, cks_pkg::ADDR_CLR, 32'h3);
  endtask

  task automatic t_shield_off();
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h8a);
    repeat (2) @(posedge i_clk_sys);
    check(32'({o_shield_en, o_low_power}), 3, 3);
    apb(1'b1, cks_pkg::ADDR_CFG, 32'h0a);
    repeat (2) @(posedge i_clk_sys);
    check(32'({o_shield_en, o_afe_en}), 0, 0);
    apb(1'b0, cks_pkg::ADDR_CHG, 32'h0);
    check(rd, 0, 0);
    apb(1'b0, cks_pkg::ADDR_BASE, 32'h0);
    check(rd, 0, 0);
  endtask

  task automatic end_sim();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk_sys);
    num_errors++;
    end_sim();
  end

  initial begin
    {i_nrst, i_psel, i_penable, i_pwrite, wake_seen} = 5'h0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    up = 8'd40;
    dn = 8'd20;
    num_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    @(posedge i_clk_sys);
    t_reset();
    t_normal();
    t_clocks();
    t_repeat();
    t_mask();
    t_auto();
    t_shield_off();
    end_sim();
  end
endmodule
